/* File: tmsb_pkg.sv */
package tmsb_pkg;
  localparam int         NCH        = 5;
  localparam int         CW         = 16;
  localparam int         STAT_W     = 11;
  // Register byte offsets
  localparam logic [7:0] ADR_MODE   = 8'h00;
  localparam logic [7:0] ADR_FUNC   = 8'h04;
  localparam logic [7:0] ADR_CTRL   = 8'h08;
  localparam logic [7:0] ADR_STAT   = 8'h0C;
  localparam logic [7:0] ADR_MASK   = 8'h10;
  localparam logic [2:0] GRP_CNT    = 3'h1;
  localparam logic [2:0] GRP_CMPA   = 3'h2;
  localparam logic [2:0] GRP_CMPB   = 3'h3;
  localparam logic [2:0] GRP_BUF    = 3'h4;
  // Reset values and read-only ones
  localparam logic [7:0] MODE_RST   = 8'h80;
  localparam logic [7:0] MODE_ONES  = 8'h80;
  localparam logic [7:0] FUNC_RST   = 8'hC0;
  localparam logic [7:0] FUNC_ONES  = 8'hC0;
  localparam logic [15:0] CMP_RST   = 16'hFFFF;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_MIN   = 16'h0000;
  // Field positions
  localparam int         MODE_TWO_PHASE = 6;
  localparam int         MODE_OVF_COND  = 5;
  localparam int         CTRL_SYNC_LSB  = 8;
  localparam int         CTRL_CLRB_LSB  = 16;
  localparam int         STAT_OVF       = 0;
  localparam int         STAT_MA_LSB    = 1;
  localparam int         STAT_MB_LSB    = 6;
endpackage

/* File: tmsb_quad.sv */
`timescale 1ns/1ps
// Two-phase edge decoder; both pins pass two flip-flops first
module tmsb_quad (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic a_i,
  input  wire logic b_i,
  output logic      up_o,
  output logic      dn_o
);
  typedef struct packed {
    logic a1, a2, aq, b1, b2, bq, up, dn;
  } tmsb_quad_t;
  tmsb_quad_t st, nx;
  logic ea, eb, same;

  always_comb begin
    nx    = st;
    nx.a1 = a_i;
    nx.a2 = st.a1;
    nx.aq = st.a2;
    nx.b1 = b_i;
    nx.b2 = st.b1;
    nx.bq = st.b2;
    ea    = st.a2 ^ st.aq;
    eb    = st.b2 ^ st.bq;
    same  = st.a2 ~^ st.b2;
    // Both pins moving at once carry no direction, so it is dropped
    // B leading A counts up; A leading B counts down
    nx.up = (ea & ~eb & same) | (eb & ~ea & ~same);
    nx.dn = (ea & ~eb & ~same) | (eb & ~ea & same);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign up_o = st.up;
  assign dn_o = st.dn;
endmodule // tmsb_quad

/* File: tmsb_chan.sv */
`timescale 1ns/1ps
// One 16-bit counter with two compare values and a PWM output
module tmsb_chan #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         step_i,
  input  wire logic         up_i,
  input  wire logic         ld_i,
  input  wire logic [W-1:0] ld_val_i,
  input  wire logic         ext_clr_i,
  input  wire logic         clr_on_b_i,
  input  wire logic         pwm_en_i,
  input  wire logic [W-1:0] cmp_a_i,
  input  wire logic [W-1:0] cmp_b_i,
  output logic [W-1:0]      cnt_o,
  output logic              pwm_o,
  output logic              match_a_o,
  output logic              match_b_o,
  output logic              ovf_o,
  output logic              unf_o,
  output logic              clr_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pwm, ma, mb, ovf, unf;
  } tmsb_chan_t;
  tmsb_chan_t st, nx;

  assign clr_o = step_i & clr_on_b_i & (st.cnt == cmp_b_i);

  always_comb begin
    nx     = st;
    nx.ma  = 1'b0;
    nx.mb  = 1'b0;
    nx.ovf = 1'b0;
    nx.unf = 1'b0;
    if (ld_i) begin
      nx.cnt = ld_val_i;
    end else if (clr_o | ext_clr_i) begin
      nx.cnt = '0;
    end else if (step_i) begin
      if (up_i) begin
        nx.cnt = st.cnt + 1'b1;
        nx.ovf = (st.cnt == {W{1'b1}});
      end else begin
        nx.cnt = st.cnt - 1'b1;
        nx.unf = (st.cnt == '0);
      end
    end
    // A match is an arrival, so a parked counter raises it only once
    if (nx.cnt != st.cnt) begin
      nx.ma = (nx.cnt == cmp_a_i);
      nx.mb = (nx.cnt == cmp_b_i);
    end
    if (!pwm_en_i) begin
      nx.pwm = 1'b0;
    end else if (nx.mb) begin
      nx.pwm = 1'b0;
    end else if (nx.ma) begin
      nx.pwm = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign cnt_o     = st.cnt;
  assign pwm_o     = st.pwm;
  assign match_a_o = st.ma;
  assign match_b_o = st.mb;
  assign ovf_o     = st.ovf;
  assign unf_o     = st.unf;
endmodule // tmsb_chan

/* File: tmsb_timer.sv */
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module tmsb_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        standby_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        phase_input_a_i,
  input  wire logic        phase_input_b_i,
  output logic      [4:0]  chan_io_a_pin_o,
  output logic      [4:0]  chan_io_a_pin_oe_o,
  output logic             irq_o
);
  localparam int N = tmsb_pkg::NCH;

  typedef struct packed {
    logic [7:0]        mode;
    logic [7:0]        func;
    logic [4:0]        start;
    logic [1:0]        sync;
    logic [4:0]        clrb;
    logic [10:0]       status;
    logic [10:0]       mask;
    logic [4:0][15:0]  cmp_a;
    logic [4:0][15:0]  cmp_b;
    logic [3:0][15:0]  bufr;
    logic              ack;
    logic [31:0]       dat;
    logic              irq;
  } tmsb_regs_t;

  tmsb_regs_t  st, nx;
  logic [4:0]  step, up_dir, cnt_ld, ext_clr, clr_vec;
  logic [4:0]  match_a, match_b, pwm, ovf, unf;
  logic [4:0][15:0] cnt;
  logic [15:0] ld_val;
  logic        q_up, q_dn, req, wr, rd_done, ovf_ev;
  logic [2:0]  grp, idx;
  logic [10:0] clr_bits;
  logic [15:0] mask16;

  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] d,
                                          input logic [1:0] s);
    merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // ==========================================================
  // Counting engines
  tmsb_quad u_quad (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .a_i   (phase_input_a_i),
    .b_i   (phase_input_b_i),
    .up_o  (q_up),
    .dn_o  (q_dn)
  );

  always_comb begin
    step   = st.start;
    up_dir = 5'h1F;
    // Phase pins replace the normal count source on channel 2
    if (st.mode[tmsb_pkg::MODE_TWO_PHASE]) begin
      step[2]   = st.start[2] & (q_up | q_dn);
      up_dir[2] = q_up;
    end
    ext_clr    = 5'h00;
    ext_clr[0] = st.sync[0] & st.sync[1] & clr_vec[1];
    ext_clr[1] = st.sync[0] & st.sync[1] & clr_vec[0];
  end

  for (genvar i = 0; i < N; i++) begin : g_ch
    tmsb_chan #(.W(tmsb_pkg::CW)) u_chan (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .step_i     (step[i]),
      .up_i       (up_dir[i]),
      .ld_i       (cnt_ld[i]),
      .ld_val_i   (ld_val),
      .ext_clr_i  (ext_clr[i]),
      .clr_on_b_i (st.clrb[i]),
      .pwm_en_i   (st.mode[i]),
      .cmp_a_i    (st.cmp_a[i]),
      .cmp_b_i    (st.cmp_b[i]),
      .cnt_o      (cnt[i]),
      .pwm_o      (pwm[i]),
      .match_a_o  (match_a[i]),
      .match_b_o  (match_b[i]),
      .ovf_o      (ovf[i]),
      .unf_o      (unf[i]),
      .clr_o      (clr_vec[i])
    );

    pwm_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(st.mode[i]) && match_a[i] && !match_b[i] |-> pwm[i])
      else $error("PWM output not high after A match");
    pwm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(st.mode[i]) |-> !pwm[i] && !chan_io_a_pin_o[i])
      else $error("PWM output active outside PWM mode");
  end

  // ==========================================================
  // Bus slave and registers
  always_comb begin
    nx       = st;
    req      = wb_cyc_i & wb_stb_i;
    wr       = req & st.ack & wb_we_i;
    rd_done  = req & st.ack & ~wb_we_i;
    grp      = wb_adr_i[7:5];
    idx      = wb_adr_i[4:2];
    cnt_ld   = 5'h00;
    ld_val   = 16'h0000;
    clr_bits = '0;
    mask16   = merge16({5'h00, st.mask}, wb_dat_i[15:0], wb_sel_i[1:0]);
    nx.ack   = req & ~st.ack;
    nx.dat   = 32'h0000_0000;
    if (req & ~st.ack & ~wb_we_i) begin
      if (wb_adr_i == tmsb_pkg::ADR_MODE) begin
        nx.dat[7:0] = st.mode;
      end else if (wb_adr_i == tmsb_pkg::ADR_FUNC) begin
        nx.dat[7:0] = st.func;
      end else if (wb_adr_i == tmsb_pkg::ADR_CTRL) begin
        nx.dat[4:0] = st.start;
        nx.dat[tmsb_pkg::CTRL_SYNC_LSB +: 2] = st.sync;
        nx.dat[tmsb_pkg::CTRL_CLRB_LSB +: 5] = st.clrb;
      end else if (wb_adr_i == tmsb_pkg::ADR_STAT) begin
        nx.dat[10:0] = st.status;
      end else if (wb_adr_i == tmsb_pkg::ADR_MASK) begin
        nx.dat[10:0] = st.mask;
      end else if (wb_adr_i[1:0] == 2'b00 && idx < 3'(N)) begin
        if (grp == tmsb_pkg::GRP_CNT) begin
          nx.dat[15:0] = cnt[idx];
        end else if (grp == tmsb_pkg::GRP_CMPA) begin
          nx.dat[15:0] = st.cmp_a[idx];
        end else if (grp == tmsb_pkg::GRP_CMPB) begin
          nx.dat[15:0] = st.cmp_b[idx];
        end else if (grp == tmsb_pkg::GRP_BUF && idx < 3'h4) begin
          nx.dat[15:0] = st.bufr[idx[1:0]];
        end
      end
    end
    // Only bits actually returned are cleared, so a late event survives
    if (rd_done && wb_adr_i == tmsb_pkg::ADR_STAT) begin
      clr_bits = st.dat[10:0];
    end
    if (wr) begin
      if (wb_adr_i == tmsb_pkg::ADR_MODE && wb_sel_i[0]) begin
        nx.mode = wb_dat_i[7:0] | tmsb_pkg::MODE_ONES;
      end else if (wb_adr_i == tmsb_pkg::ADR_FUNC && wb_sel_i[0]) begin
        // Bits 5:4 are stored as written; keeping them zero is up to software
        nx.func = wb_dat_i[7:0] | tmsb_pkg::FUNC_ONES;
      end else if (wb_adr_i == tmsb_pkg::ADR_CTRL) begin
        if (wb_sel_i[0]) begin
          nx.start = wb_dat_i[4:0];
        end
        if (wb_sel_i[1]) begin
          nx.sync = wb_dat_i[tmsb_pkg::CTRL_SYNC_LSB +: 2];
        end
        if (wb_sel_i[2]) begin
          nx.clrb = wb_dat_i[tmsb_pkg::CTRL_CLRB_LSB +: 5];
        end
      end else if (wb_adr_i == tmsb_pkg::ADR_MASK) begin
        nx.mask = mask16[10:0];
      end else if (wb_adr_i[1:0] == 2'b00 && idx < 3'(N)) begin
        if (grp == tmsb_pkg::GRP_CNT) begin
          ld_val      = merge16(cnt[idx], wb_dat_i[15:0], wb_sel_i[1:0]);
          cnt_ld[idx] = 1'b1;
          // A preset of one joined counter presets its partner too
          if (idx < 3'h2 && st.sync[idx[0]] && st.sync[~idx[0]]) begin
            cnt_ld[1:0] = 2'b11;
          end
        end else if (grp == tmsb_pkg::GRP_CMPA) begin
          nx.cmp_a[idx] = merge16(st.cmp_a[idx], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (grp == tmsb_pkg::GRP_CMPB) begin
          nx.cmp_b[idx] = merge16(st.cmp_b[idx], wb_dat_i[15:0], wb_sel_i[1:0]);
        end else if (grp == tmsb_pkg::GRP_BUF && idx < 3'h4) begin
          nx.bufr[idx[1:0]] = merge16(st.bufr[idx[1:0]], wb_dat_i[15:0], wb_sel_i[1:0]);
        end
      end
    end
    // Buffer transfer wins over a same-cycle write to the compare value
    if (st.func[0] && match_a[3]) begin
      nx.cmp_a[3] = st.bufr[0];
    end
    if (st.func[1] && match_b[3]) begin
      nx.cmp_b[3] = st.bufr[1];
    end
    if (st.func[2] && match_a[4]) begin
      nx.cmp_a[4] = st.bufr[2];
    end
    if (st.func[3] && match_b[4]) begin
      nx.cmp_b[4] = st.bufr[3];
    end
    // Underflow counts only when the flag condition bit is clear
    ovf_ev    = ovf[2] | (unf[2] & ~st.mode[tmsb_pkg::MODE_OVF_COND]);
    nx.status = (st.status & ~clr_bits) | {match_b, match_a, ovf_ev};
    if (standby_i) begin
      nx.mode = tmsb_pkg::MODE_RST;
      nx.func = tmsb_pkg::FUNC_RST;
    end
    nx.irq = |(nx.status & nx.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= '0;
      st.mode  <= tmsb_pkg::MODE_RST;
      st.func  <= tmsb_pkg::FUNC_RST;
      st.cmp_a <= {N{tmsb_pkg::CMP_RST}};
      st.cmp_b <= {N{tmsb_pkg::CMP_RST}};
      st.bufr  <= {4{tmsb_pkg::CMP_RST}};
    end else begin
      st <= nx;
    end
  end

  assign wb_dat_o           = st.dat;
  assign wb_ack_o           = st.ack;
  assign irq_o              = st.irq;
  assign chan_io_a_pin_o    = pwm;
  assign chan_io_a_pin_oe_o = st.mode[4:0];

  // ==========================================================
  // Checks
  mode_bit7_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == tmsb_pkg::ADR_MODE |-> wb_dat_o[7])
    else $error("Mode bit 7 not reading 1");
  mode_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.mode[7])
    else $error("Mode bit 7 not held at 1");
  func_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.func[7:6] == 2'b11)
    else $error("Function bits 7:6 not 1");
  mode_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) || $past(standby_i) |-> st.mode == tmsb_pkg::MODE_RST
      && st.func == tmsb_pkg::FUNC_RST)
    else $error("Mode or function register not at reset value");
  ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf[2] |=> st.status[tmsb_pkg::STAT_OVF])
    else $error("Overflow did not set the flag");
  ovf_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.status[tmsb_pkg::STAT_OVF]) |->
      $past(ovf[2] | (unf[2] & ~st.mode[tmsb_pkg::MODE_OVF_COND])))
    else $error("Overflow flag set without a valid cause");
  phase_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.mode[6] && st.start[2] && q_up && !cnt_ld[2] && !st.clrb[2]
      |=> cnt[2] == $past(cnt[2]) + 16'h0001)
    else $error("Phase count up step missing");
  normal_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.mode[6] && st.start[2] && !cnt_ld[2] && !st.clrb[2]
      |=> cnt[2] == $past(cnt[2]) + 16'h0001)
    else $error("Normal count on channel 2 missing");
  buf_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.func[0] && match_a[3] |=> st.cmp_a[3] == $past(st.bufr[0]))
    else $error("Buffer A3 not copied at match");
  sync_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.sync == 2'b11 && clr_vec[1] && !cnt_ld[0] |=> cnt[0] == 16'h0000)
    else $error("Joined counter not cleared with partner");
endmodule // tmsb_timer

/* File: tmsb_encoder.sv */
`timescale 1ns/1ps
// ==========================================
// Encoder partner: Gray steps, B leads A when counting up
module tmsb_encoder (
  input  wire logic clk_i,
  input  wire logic step_i,
  input  wire logic up_i,
  output logic      a_o,
  output logic      b_o
);
  logic [1:0] idx = 2'h0;
  always_ff @(posedge clk_i) begin
    if (step_i) begin
      idx <= up_i ? idx + 2'h1 : idx - 2'h1;
    end
  end
  // One pin moves per step, so the pins never change together
  assign a_o = idx[1];
  assign b_o = idx[1] ^ idx[0];
endmodule // tmsb_encoder

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk_i;
  logic        rst_i;
  logic        standby_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pha;
  logic        phb;
  logic [4:0]  pin_o;
  logic [4:0]  pin_oe;
  logic        irq_o;
  logic        enc_step;
  logic        enc_up;
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] c;
  int          mode_m;
  int          n_mismatch;
  int          num_checks;

  tmsb_timer u_tmsb_timer (
    .clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .phase_input_a_i(pha), .phase_input_b_i(phb),
    .chan_io_a_pin_o(pin_o), .chan_io_a_pin_oe_o(pin_oe), .irq_o(irq_o)
  );
  tmsb_encoder u_tmsb_encoder (
    .clk_i(clk_i), .step_i(enc_step), .up_i(enc_up), .a_o(pha), .b_o(phb)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle; request held until the edge that samples ack
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    // Ack is looked at where it has settled; the next rising edge samples it
    do begin
      @(negedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  // Pins pass a synchroniser and decoder, so allow settling time
  task automatic enc(input logic up);
    @(posedge clk_i);
    enc_step <= 1'b1;
    enc_up   <= up;
    @(posedge clk_i);
    enc_step <= 1'b0;
    idle(8);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    standby_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    enc_step = 1'b0;
    enc_up = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    void'($urandom(5));
    idle(3);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk(8'h00, 32'h80);
    rchk(8'h04, 32'hC0);
    rchk(8'h08, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'hFC, 32'h0);
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      wr(8'h00, v);
      mode_m = 32'h80 | (v & 32'h7F);
      rchk(8'h00, mode_m);
      chk(pin_oe, mode_m & 32'h1F);
      wr(8'h04, v & 32'h0F);
      rchk(8'h04, 32'hC0 | (v & 32'h0F));
    end
    standby_i <= 1'b1;
    idle(2);
    standby_i <= 1'b0;
    rchk(8'h00, 32'h80);
    rchk(8'h04, 32'hC0);
    chk(pin_oe, 32'h0);
    $display("test registers done");

    v = $urandom & 32'hFFFF;
    wr(8'h08, 32'h300);
    wr(8'h20, v);
    rchk(8'h24, v);
    wr(8'h08, 32'h200);
    wr(8'h20, 32'h11);
    rchk(8'h24, v);
    wr(8'h08, 32'h0);
    wr(8'h24, 32'h55);
    rchk(8'h20, 32'h11);
    $display("test sync done");

    for (int i = 0; i < 5; i++) begin
      wr(8'h08, 32'h1 << (16 + i));
      wr(8'(8'h20 + 4 * i), 32'h0);
      wr(8'(8'h40 + 4 * i), 32'd10);
      wr(8'(8'h60 + 4 * i), 32'd20);
      wr(8'h00, 32'h1 << i);
      wr(8'h08, (32'h1 << (16 + i)) | (32'h1 << i));
      idle(5 + $urandom % 60);
      wr(8'h08, 32'h1 << (16 + i));
      bus(1'b0, 8'(8'h20 + 4 * i), 32'h0);
      c = rd;
      chk(pin_o, {31'h0, c >= 10 && c < 20} << i);
      chk(pin_oe, 32'h1 << i);
      chk({31'h0, c < 21}, 32'h1);
    end
    wr(8'h00, 32'h0);
    idle(2);
    chk(pin_o, 32'h0);
    $display("test pwm done");

    wr(8'h04, 32'h01);
    wr(8'h80, 32'd30);
    wr(8'h84, 32'd5);
    wr(8'h2C, 32'h0);
    wr(8'h4C, 32'd10);
    wr(8'h6C, 32'd25);
    wr(8'h08, 32'h80008);
    idle(30);
    wr(8'h08, 32'h0);
    rchk(8'h4C, 32'd30);
    rchk(8'h6C, 32'd25);
    $display("test buffer done");

    wr(8'h10, 32'h1);
    wr(8'h00, 32'h40);
    wr(8'h08, 32'h4);
    wr(8'h28, 32'h0);
    bus(1'b0, 8'h0C, 32'h0);
    enc(1'b0);
    chk(irq_o, 32'h1);
    rchk(8'h0C, 32'h1);
    idle(2);
    chk(irq_o, 32'h0);
    rchk(8'h28, 32'hFFFF);
    repeat (3) enc(1'b1);
    rchk(8'h0C, 32'h1);
    rchk(8'h28, 32'h2);
    wr(8'h00, 32'h60);
    wr(8'h28, 32'h0);
    enc(1'b0);
    rchk(8'h0C, 32'h0);
    rchk(8'h28, 32'hFFFF);
    wr(8'h10, 32'h0);
    enc(1'b1);
    chk(irq_o, 32'h0);
    rchk(8'h0C, 32'h1);
    $display("test two phase done");
    end_of_test();
  end
endmodule // testbench
